// >>> core/tlic_ctrl.v
/*
 * Two-level interrupt controller: flag keeping, edge detection of six external
 * pins and level detection of pins 0 and 1, per-machine-cycle polling and priority resolution,
 * hardware call sequencing and in-service tracking per level.
 * Assumes a processor core on the same clock that reports the last cycle
 * of each instruction, blocking instructions and return-from-interrupt,
 * and peripherals that pulse their flag-set inputs for one clock.
 */
// Notes on behaviour
// [R1] Twelve sources, two levels, own flag/enable/vector.
// [R2] Pins 0,1 edge or level; high-then-low sets.
// [R3] Edge-mode pin 0,1 flags clear on vectoring.
// [R4] Level-mode pin 0,1 flags follow pin, not cleared.
// [R5] Requester holds pin a machine cycle; level low.
// [R6] Pins 2-5 edge only; optional hardware clear.
// [R7] Timer 0,1 flags cleared on vectoring.
// [R8] Timer 2 request is OR, software clears.
// [R9] Watchdog flag requests when its enable set.
// [R10] Serial requests OR rx/tx; never hardware cleared.
// [R11] Software may write every flag, forcing requests.
// [R12] Per-source enables plus global enable mask.
// [R13] No lower preemption; fixed order within level.
// [R14] Flags sampled and resolved each machine cycle.
// [R15] Call only when three conditions all hold.
// [R16] Requests are not latched between polls.
// [R17] Call pushes PC only, then loads vector.
// [R18] Fixed vector address per source.
// [R19] Only return-from-interrupt ends in-service state.
// [R20] Pins sampled at C3; timer flags polled next.
// [R21] Call lasts four machine cycles.
// [R22] Worst single-source response twelve machine cycles.
// [R23] One in-service bit per level, highest cleared.
`timescale 1ns/10ps
`include "tlic_map.vh"

module tlic_ctrl (
  input  wire        clk_in,
  input  wire        srst_in,
  input  wire [5:0]  ext_irq_pin_in,
  input  wire        ext0_trigger_type_in,
  input  wire        ext1_trigger_type_in,
  input  wire [3:0]  auto_clear_select_in,
  input  wire        tmr0_overflow_set_in,
  input  wire        tmr1_overflow_set_in,
  input  wire        tmr2_overflow_set_in,
  input  wire        tmr2_external_set_in,
  input  wire        wdog_timeout_set_in,
  input  wire        rx_done_set_in,
  input  wire        tx_done_set_in,
  input  wire        rx1_done_set_in,
  input  wire        tx1_done_set_in,
  input  wire        sw_flag_wr_in,
  input  wire [3:0]  sw_flag_idx_in,
  input  wire        sw_flag_val_in,
  input  wire [11:0] source_enable_in,
  input  wire        global_enable_in,
  input  wire [11:0] level_select_in,
  input  wire        last_cycle_in,
  input  wire        blocking_instr_in,
  input  wire        return_from_interrupt_in,
  output reg  [14:0] flag_out,
  output reg  [1:0]  in_service_out,
  output reg         push_pc_out,
  output reg         call_busy_out,
  output reg         vector_load_out,
  output reg  [15:0] vector_out,
  output reg  [3:0]  call_source_out,
  output reg         call_level_out,
  output reg  [1:0]  mcyc_phase_out
);

  // ========================================================================
  // Machine-cycle phase
  // ========================================================================
  localparam ST_IDLE = 1'b0;
  localparam ST_CALL = 1'b1;

  reg [1:0] phase;
  reg       state;
  reg [4:0] call_cnt;

  always @(posedge clk_in) begin
    if (srst_in) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // ========================================================================
  // External pin synchronisers and C3 sampling
  // ========================================================================
  // The requester must hold each level for a machine cycle, otherwise a
  // short pulse can fall between two C3 samples and be missed.
  reg [5:0] pin_meta;
  reg [5:0] pin_sync;
  reg [5:0] pin_samp;

  always @(posedge clk_in) begin
    if (srst_in) begin
      pin_meta <= 6'h3F;
      pin_sync <= 6'h3F;
      pin_samp <= 6'h3F;
    end else begin
      pin_meta <= ext_irq_pin_in;
      pin_sync <= pin_meta;
      if (phase == `TLIC_PHASE_C3) begin
        pin_samp <= pin_sync; // see [R20] [R5]
      end
    end
  end

  wire       at_c3 = (phase == `TLIC_PHASE_C3);
  wire [5:0] fall  = pin_samp & ~pin_sync & {6{at_c3}};
  wire [5:0] low3  = ~pin_sync & {6{at_c3}};
  wire [5:0] high3 = pin_sync & {6{at_c3}};

  // ========================================================================
  // Flag set and clear terms
  // ========================================================================
  reg  [14:0] hw_set;
  reg  [14:0] hw_clr;
  reg         call_start;
  reg  [3:0]  win_src;

  always @* begin
    hw_set = 15'h0000;
    hw_clr = 15'h0000;
    // Edge mode sets on a fall; level mode makes the flag track the pin.
    hw_set[`TLIC_F_EXT0] = ext0_trigger_type_in ? fall[0] : low3[0]; // see [R2]
    hw_set[`TLIC_F_EXT1] = ext1_trigger_type_in ? fall[1] : low3[1]; // see [R2]
    hw_clr[`TLIC_F_EXT0] = ~ext0_trigger_type_in & high3[0]; // see [R4]
    hw_clr[`TLIC_F_EXT1] = ~ext1_trigger_type_in & high3[1]; // see [R4]
    hw_set[`TLIC_F_EXT5:`TLIC_F_EXT2] = fall[5:2]; // see [R6]
    hw_set[`TLIC_F_TMR0]     = tmr0_overflow_set_in;
    hw_set[`TLIC_F_TMR1]     = tmr1_overflow_set_in;
    hw_set[`TLIC_F_TMR2_OVF] = tmr2_overflow_set_in;
    hw_set[`TLIC_F_TMR2_EXT] = tmr2_external_set_in;
    hw_set[`TLIC_F_WDOG]     = wdog_timeout_set_in;
    hw_set[`TLIC_F_RX0]      = rx_done_set_in;
    hw_set[`TLIC_F_TX0]      = tx_done_set_in;
    hw_set[`TLIC_F_RX1]      = rx1_done_set_in;
    hw_set[`TLIC_F_TX1]      = tx1_done_set_in;
    if (call_start) begin
      if (win_src == `TLIC_S_EXT0 && ext0_trigger_type_in) begin
        hw_clr[`TLIC_F_EXT0] = 1'b1; // see [R3]
      end else if (win_src == `TLIC_S_EXT1 && ext1_trigger_type_in) begin
        hw_clr[`TLIC_F_EXT1] = 1'b1; // see [R3]
      end else if (win_src == `TLIC_S_TMR0) begin
        hw_clr[`TLIC_F_TMR0] = 1'b1; // see [R7]
      end else if (win_src == `TLIC_S_TMR1) begin
        hw_clr[`TLIC_F_TMR1] = 1'b1; // see [R7]
      end else if (win_src >= `TLIC_S_EXT2 && win_src < `TLIC_S_WDOG) begin
        // Sources 7..10 map to flags 2..5 and select bits 0..3.
        if (auto_clear_select_in[win_src[1:0] + 2'h1]) begin
          hw_clr[win_src - 4'h5] = 1'b1; // see [R6]
        end
      end
      // Timer 2, serial and watchdog flags stay set on vectoring.
      // see [R8] [R9] [R10]
    end
  end

  // ========================================================================
  // Flag registers
  // ========================================================================
  // A hardware set beats both a software clear and a vectoring clear in
  // the same clock, so no event is ever dropped.
  genvar gi;
  generate
    for (gi = 0; gi < `TLIC_NFLAGS; gi = gi + 1) begin : g_flag
      wire sw_hit = sw_flag_wr_in && (sw_flag_idx_in == gi);
      wire base   = sw_hit ? sw_flag_val_in : flag_out[gi]; // see [R11]
      always @(posedge clk_in) begin
        if (srst_in) begin
          flag_out[gi] <= 1'b0;
        end else begin
          flag_out[gi] <= (base & ~hw_clr[gi]) | hw_set[gi];
        end
      end
    end
  endgenerate

  // ========================================================================
  // Snapshot and per-source requests
  // ========================================================================
  // Flags are snapshot at the start of each machine cycle, so a timer flag
  // set at C3 is first polled in the following machine cycle.
  reg [14:0] snap;

  always @(posedge clk_in) begin
    if (srst_in) begin
      snap <= `TLIC_RST_FLAGS;
    end else if (phase == `TLIC_PHASE_SNAP) begin
      snap <= flag_out; // see [R14] [R20]
    end
  end

  wire [11:0] src_req;
  assign src_req[`TLIC_S_EXT0] = snap[`TLIC_F_EXT0];
  assign src_req[`TLIC_S_TMR0] = snap[`TLIC_F_TMR0];
  assign src_req[`TLIC_S_EXT1] = snap[`TLIC_F_EXT1];
  assign src_req[`TLIC_S_TMR1] = snap[`TLIC_F_TMR1];
  assign src_req[`TLIC_S_SER0] = snap[`TLIC_F_RX0] | snap[`TLIC_F_TX0];
  assign src_req[`TLIC_S_TMR2] = snap[`TLIC_F_TMR2_OVF] |
                                 snap[`TLIC_F_TMR2_EXT]; // see [R8]
  assign src_req[`TLIC_S_SER1] = snap[`TLIC_F_RX1] |
                                 snap[`TLIC_F_TX1]; // see [R10]
  assign src_req[10:7]         = snap[`TLIC_F_EXT5:`TLIC_F_EXT2];
  // The watchdog enable is bit 11 of source_enable_in.
  assign src_req[`TLIC_S_WDOG] = snap[`TLIC_F_WDOG]; // see [R9]

  wire [11:0] live   = src_req & source_enable_in &
                       {12{global_enable_in}}; // see [R12] [R1]
  wire [11:0] live_h = live & level_select_in;
  wire [11:0] live_l = live & ~level_select_in;

  // ========================================================================
  // Priority resolution
  // ========================================================================
  reg        win_found;
  reg        win_level;
  integer    k;

  always @* begin
    win_found = 1'b0;
    win_level = 1'b0;
    win_src   = 4'h0;
    // Walk from lowest to highest so the highest in order is left last.
    for (k = `TLIC_NSRC - 1; k >= 0; k = k - 1) begin
      if (live_l[k] && in_service_out == 2'h0) begin
        win_found = 1'b1;
        win_level = 1'b0;
        win_src   = k[3:0];
      end
    end
    for (k = `TLIC_NSRC - 1; k >= 0; k = k - 1) begin
      if (live_h[k] && !in_service_out[1]) begin
        win_found = 1'b1; // see [R13]
        win_level = 1'b1;
        win_src   = k[3:0];
      end
    end
    // Nothing is remembered: a request missing at this poll is dropped.
    call_start = win_found && (phase == `TLIC_PHASE_POLL) &&
                 last_cycle_in && !blocking_instr_in &&
                 (state == ST_IDLE); // see [R15] [R16]
  end

  function [15:0] vec_of;
    input [3:0] s;
    begin
      case (s)
        4'h0:    vec_of = `TLIC_VEC_EXT0;
        4'h1:    vec_of = `TLIC_VEC_TMR0;
        4'h2:    vec_of = `TLIC_VEC_EXT1;
        4'h3:    vec_of = `TLIC_VEC_TMR1;
        4'h4:    vec_of = `TLIC_VEC_SER0;
        4'h5:    vec_of = `TLIC_VEC_TMR2;
        4'h6:    vec_of = `TLIC_VEC_SER1;
        4'h7:    vec_of = `TLIC_VEC_EXT2;
        4'h8:    vec_of = `TLIC_VEC_EXT3;
        4'h9:    vec_of = `TLIC_VEC_EXT4;
        4'hA:    vec_of = `TLIC_VEC_EXT5;
        default: vec_of = `TLIC_VEC_WDOG;
      endcase
    end
  endfunction

  // ========================================================================
  // Hardware call sequence and in-service tracking
  // ========================================================================
  always @(posedge clk_in) begin
    if (srst_in) begin
      state           <= ST_IDLE;
      call_cnt        <= 5'h00;
      push_pc_out     <= 1'b0;
      call_busy_out   <= 1'b0;
      vector_load_out <= 1'b0;
      vector_out      <= `TLIC_RST_VECTOR;
      call_source_out <= 4'h0;
      call_level_out  <= 1'b0;
      in_service_out  <= `TLIC_RST_INSERV;
      mcyc_phase_out  <= 2'h0;
    end else begin
      mcyc_phase_out  <= phase;
      push_pc_out     <= 1'b0;
      vector_load_out <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (call_start) begin
            state           <= ST_CALL;
            call_cnt        <= 5'h00;
            push_pc_out     <= 1'b1; // see [R17]
            call_busy_out   <= 1'b1;
            vector_out      <= vec_of(win_src); // see [R18]
            call_source_out <= win_src;
            call_level_out  <= win_level;
          end
        end
        default: begin
          call_cnt <= call_cnt + 5'h01;
          if (call_cnt == `TLIC_CALL_CLKS - 1) begin
            state           <= ST_IDLE; // see [R21] [R22]
            call_busy_out   <= 1'b0;
            vector_load_out <= 1'b1; // see [R17]
          end
        end
      endcase
      // When a call and a return fall in the same clock, the call wins: it
      // sets its in-service bit and the return is ignored.
      if (call_start) begin
        in_service_out[win_level] <= 1'b1; // see [R23]
      end else if (return_from_interrupt_in) begin
        if (in_service_out[1]) begin
          in_service_out[1] <= 1'b0; // see [R19] [R23]
        end else begin
          in_service_out[0] <= 1'b0; // see [R19]
        end
      end
    end
  end

endmodule

// >>> core/tlic_map.vh
/*
 * Constants of the two-level interrupt controller: machine-cycle timing,
 * flag positions, source order, vectors and reset values.
 * Assumes a 20 MHz system clock and four clocks to a machine cycle.
 */
`ifndef TLIC_MAP_VH
`define TLIC_MAP_VH

// ==========================================================================
// Timing
// ==========================================================================
`define TLIC_CLK_PERIOD_NS   50
`define TLIC_CLKS_PER_MCYC   4
`define TLIC_PHASE_C3        2'h2
`define TLIC_PHASE_POLL      2'h3
`define TLIC_PHASE_SNAP      2'h0
`define TLIC_CALL_MCYC       4
`define TLIC_CALL_CLKS       (`TLIC_CALL_MCYC * `TLIC_CLKS_PER_MCYC)
`define TLIC_MAX_LAT_MCYC    12
`define TLIC_MAX_LAT_CLKS    (`TLIC_MAX_LAT_MCYC * `TLIC_CLKS_PER_MCYC)

// ==========================================================================
// Flag positions
// ==========================================================================
`define TLIC_NFLAGS          15
`define TLIC_F_EXT0          0
`define TLIC_F_EXT1          1
`define TLIC_F_EXT2          2
`define TLIC_F_EXT5          5
`define TLIC_F_TMR0          6
`define TLIC_F_TMR1          7
`define TLIC_F_TMR2_OVF      8
`define TLIC_F_TMR2_EXT      9
`define TLIC_F_WDOG          10
`define TLIC_F_RX0           11
`define TLIC_F_TX0           12
`define TLIC_F_RX1           13
`define TLIC_F_TX1           14

// ==========================================================================
// Sources in fixed order, highest first
// ==========================================================================
`define TLIC_NSRC            12
`define TLIC_S_EXT0          0
`define TLIC_S_TMR0          1
`define TLIC_S_EXT1          2
`define TLIC_S_TMR1          3
`define TLIC_S_SER0          4
`define TLIC_S_TMR2          5
`define TLIC_S_SER1          6
`define TLIC_S_EXT2          7
`define TLIC_S_WDOG          11

// ==========================================================================
// Vectors
// ==========================================================================
`define TLIC_VEC_EXT0        16'h0003
`define TLIC_VEC_TMR0        16'h000B
`define TLIC_VEC_EXT1        16'h0013
`define TLIC_VEC_TMR1        16'h001B
`define TLIC_VEC_SER0        16'h0023
`define TLIC_VEC_TMR2        16'h002B
`define TLIC_VEC_SER1        16'h003B
`define TLIC_VEC_EXT2        16'h0043
`define TLIC_VEC_EXT3        16'h004B
`define TLIC_VEC_EXT4        16'h0053
`define TLIC_VEC_EXT5        16'h005B
`define TLIC_VEC_WDOG        16'h0063

// ==========================================================================
// Reset values
// ==========================================================================
`define TLIC_RST_FLAGS       15'h0000
`define TLIC_RST_VECTOR      16'h0000
`define TLIC_RST_INSERV      2'h0

`endif

// >>> verification/tlic_core_model.sv
/* Behavioural core and request pins on the far side of the controller.
   Assumes the controller's phase output and commands from the bench. */
`timescale 1ns/10ps
module tlic_core_model (
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  input  wire logic [1:0] phase_in,
  input  wire logic [1:0] len_in,
  input  wire logic [5:0] pin_low_in,
  output logic            last_cycle_out,
  output logic [5:0]      pin_out
);
  // ====================================
  // Instruction timing and pins
  // ====================================
  logic [1:0] icnt;
  // The bench holds every pin level for two machine cycles or more.
  assign pin_out = ~pin_low_in;
  // Steps away from the poll edge so the level is steady when sampled.
  always @(posedge clk_in) begin
    if (srst_in)
      icnt <= 2'h0;
    else if (phase_in == 2'h1)
      icnt <= (icnt >= len_in) ? 2'h0 : icnt + 2'h1;
  end
  assign last_cycle_out = (icnt >= len_in);
endmodule

// >>> verification/tlic_ctrl_assertions.sv
/* Checker of the interrupt controller's call, in-service and flag behaviour.
   Assumes one clock domain; bound to the controller at the foot. */
`timescale 1ns/10ps
module tlic_ctrl_assertions (
  input wire logic        clk_in,
  input wire logic        srst_in,
  input wire logic        ext0_trigger_type_in,
  input wire logic        tmr0_overflow_set_in,
  input wire logic        sw_flag_wr_in,
  input wire logic [3:0]  sw_flag_idx_in,
  input wire logic        sw_flag_val_in,
  input wire logic [11:0] source_enable_in,
  input wire logic        global_enable_in,
  input wire logic [11:0] level_select_in,
  input wire logic        last_cycle_in,
  input wire logic        blocking_instr_in,
  input wire logic        return_from_interrupt_in,
  input wire logic [14:0] flag_out,
  input wire logic [1:0]  in_service_out,
  input wire logic        push_pc_out,
  input wire logic        call_busy_out,
  input wire logic        vector_load_out,
  input wire logic [15:0] vector_out,
  input wire logic [3:0]  call_source_out,
  input wire logic        call_level_out
);
  // ====================================
  // Call, in-service and flag checks
  // ====================================
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  // Vectors are eight apart, with one spare slot after timer 2.
  function automatic logic [15:0] vec(input logic [3:0] s);
    return {9'h000, s + ((s > 4'h5) ? 4'h1 : 4'h0), 3'h3};
  endfunction
  a_call_gated: assert property (
    push_pc_out |-> $past(last_cycle_in) && !$past(blocking_instr_in)
    && $past(global_enable_in) && source_enable_in[call_source_out])
    else $error("call taken while not allowed");
  a_vector_map: assert property (
    push_pc_out |-> vector_out == vec(call_source_out))
    else $error("wrong vector for source");
  a_load_delay: assert property (
    push_pc_out |-> call_busy_out ##[15:16] vector_load_out)
    else $error("call length wrong");
  a_level_pick: assert property (
    push_pc_out |-> call_level_out == level_select_in[call_source_out]
    && in_service_out[call_level_out])
    else $error("call level wrong");
  a_no_preempt: assert property (
    push_pc_out |-> !$past(in_service_out[1])
    && (call_level_out || !$past(in_service_out[0])))
    else $error("equal or higher level preempted");
  a_return_from_interrupt_high: assert property (
    return_from_interrupt_in && in_service_out[1] && !call_busy_out
    |=> !in_service_out[1] && in_service_out[0] == $past(in_service_out[0]))
    else $error("return did not end high level");
  a_return_from_interrupt_low: assert property (
    return_from_interrupt_in && in_service_out == 2'h1 && !call_busy_out
    |=> in_service_out == 2'h0)
    else $error("return did not end low level");
  a_ext0_clear: assert property (
    push_pc_out && call_source_out == 4'h0
    |-> flag_out[0] == !ext0_trigger_type_in)
    else $error("pin 0 flag clearing wrong");
  a_tmr_clear: assert property (
    push_pc_out && call_source_out == 4'h1 |-> !flag_out[6])
    else $error("timer 0 flag not cleared");
  a_tmr2_keep: assert property (
    push_pc_out && call_source_out == 4'h5
    |-> flag_out[9:8] == $past(flag_out[9:8]))
    else $error("timer 2 flags changed on call");
  a_tmr_set: assert property (
    tmr0_overflow_set_in |=> flag_out[6])
    else $error("timer 0 flag not set");
  a_sw_write: assert property (
    sw_flag_wr_in && sw_flag_idx_in > 4'h1 && sw_flag_idx_in < 4'hF
    |=> flag_out[$past(sw_flag_idx_in)] == $past(sw_flag_val_in))
    else $error("software flag write lost");
  c_high_call: cover property (push_pc_out && call_level_out);
  c_nested: cover property (in_service_out == 2'h3);
  c_wdog: cover property (push_pc_out && call_source_out == 4'hB);
endmodule
bind tlic_ctrl tlic_ctrl_assertions u_chk (
  .clk_in(clk_in), .srst_in(srst_in),
  .ext0_trigger_type_in(ext0_trigger_type_in),
  .tmr0_overflow_set_in(tmr0_overflow_set_in),
  .sw_flag_wr_in(sw_flag_wr_in), .sw_flag_idx_in(sw_flag_idx_in),
  .sw_flag_val_in(sw_flag_val_in), .source_enable_in(source_enable_in),
  .global_enable_in(global_enable_in), .level_select_in(level_select_in),
  .last_cycle_in(last_cycle_in), .blocking_instr_in(blocking_instr_in),
  .return_from_interrupt_in(return_from_interrupt_in),
  .flag_out(flag_out), .in_service_out(in_service_out),
  .push_pc_out(push_pc_out), .call_busy_out(call_busy_out),
  .vector_load_out(vector_load_out), .vector_out(vector_out),
  .call_source_out(call_source_out), .call_level_out(call_level_out));

// >>> verification/tlic_ctrl_bench.sv
/* Self-checking bench of the two-level interrupt controller.
   Assumes the core model and the checker are compiled before it. */
`timescale 1ns/10ps
module tlic_ctrl_bench;
  logic        clk_in, srst_in, trig0, trig1, sw_wr, sw_val, ge, blk, ret;
  logic        last, push, busy, load, lvl;
  logic [1:0]  len, insv, phase;
  logic [3:0]  acs, sw_idx, src;
  logic [5:0]  pins, pin_low;
  logic [8:0]  pul;
  logic [11:0] sen, lsel;
  logic [14:0] flags;
  logic [15:0] vec;
  int          n_fail = 0, tests_run = 0, n_push = 0, cyc = 0, p;
  // Rows: flag index, source, vector, hardware clears the flag on call.
  logic [27:0] tbl [15] = '{28'h0000031, 28'h1200131, 28'h2700431,
    28'h38004B0, 28'h4900531, 28'h5A005B0, 28'h61000B1, 28'h73001B1,
    28'h85002B0, 28'h95002B0, 28'hAB00630, 28'hB400230, 28'hC400230,
    28'hD6003B0, 28'hE6003B0};
  tlic_ctrl uut (.clk_in(clk_in), .srst_in(srst_in), .ext_irq_pin_in(pins),
    .ext0_trigger_type_in(trig0), .ext1_trigger_type_in(trig1),
    .auto_clear_select_in(acs), .tmr0_overflow_set_in(pul[0]),
    .tmr1_overflow_set_in(pul[1]), .tmr2_overflow_set_in(pul[2]),
    .tmr2_external_set_in(pul[3]), .wdog_timeout_set_in(pul[4]),
    .rx_done_set_in(pul[5]), .tx_done_set_in(pul[6]),
    .rx1_done_set_in(pul[7]), .tx1_done_set_in(pul[8]),
    .sw_flag_wr_in(sw_wr), .sw_flag_idx_in(sw_idx), .sw_flag_val_in(sw_val),
    .source_enable_in(sen), .global_enable_in(ge), .level_select_in(lsel),
    .last_cycle_in(last), .blocking_instr_in(blk),
    .return_from_interrupt_in(ret), .flag_out(flags), .in_service_out(insv),
    .push_pc_out(push), .call_busy_out(busy), .vector_load_out(load),
    .vector_out(vec), .call_source_out(src), .call_level_out(lvl),
    .mcyc_phase_out(phase));
  tlic_core_model core (.clk_in(clk_in), .srst_in(srst_in),
    .phase_in(phase), .len_in(len), .pin_low_in(pin_low),
    .last_cycle_out(last), .pin_out(pins));
  // ====================================
  // Clock, watchdog and helpers
  // ====================================
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    if (push === 1'b1) n_push++;
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      summarize;
    end
  end
  task summarize;
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task swr(input logic [3:0] i, input logic v);
    @(posedge clk_in);
    sw_idx <= i;
    sw_val <= v;
    sw_wr <= 1'b1;
    @(posedge clk_in);
    sw_wr <= 1'b0;
  endtask
  task hw(input logic [8:0] m);
    @(posedge clk_in);
    pul <= m;
    @(posedge clk_in);
    pul <= 9'h000;
  endtask
  // Return is a blocking instruction, so no call can share its cycle.
  task return_from_interrupt;
    @(posedge clk_in);
    ret <= 1'b1;
    blk <= 1'b1;
    @(posedge clk_in);
    ret <= 1'b0;
    tick(4);
    @(posedge clk_in);
    blk <= 1'b0;
    #1;
  endtask
  // Bounded wait for the call (0) or for the vector load (1).
  task wait_for(input int what);
    int k;
    for (k = 0; k < (what ? 16 : 48); k++) begin
      @(posedge clk_in);
      #1;
      if ((what ? load : push) === 1'b1) break;
    end
    chk("call timing", k < (what ? 16 : 48), 1'b1);
  endtask
  // ====================================
  // Sequence
  // ====================================
  initial begin
    srst_in = 1'b1; trig0 = 1'b1; trig1 = 1'b1; acs = 4'h0; pul = 9'h000;
    sw_wr = 1'b0; sw_idx = 4'h0; sw_val = 1'b0; sen = 12'hFFF; ge = 1'b1;
    lsel = 12'h000; blk = 1'b0; ret = 1'b0; len = 2'h0; pin_low = 6'h00;
    tick(8);
    @(posedge clk_in);
    srst_in <= 1'b0;
    foreach (tbl[r]) begin
      @(posedge clk_in);
      acs <= {4{tbl[r][0]}};
      if (tbl[r][27:24] > 4'h5) hw(9'h001 << (tbl[r][27:24] - 4'h6));
      else swr(tbl[r][27:24], 1'b1);
      wait_for(0);
      chk("vector", vec, tbl[r][19:4]);
      chk("source", src, tbl[r][23:20]);
      chk("in service", insv, 2'h1);
      wait_for(1);
      chk("flag", flags[tbl[r][27:24]], !tbl[r][0]);
      swr(tbl[r][27:24], 1'b0);
      return_from_interrupt;
      chk("in service", insv, 2'h0);
      $display("row %0d done", r);
    end
    @(posedge clk_in);
    sen <= 12'h000;
    len <= 2'h2;
    hw(9'h022);
    p = n_push;
    tick(24);
    chk("calls", n_push, p);
    @(posedge clk_in);
    sen <= 12'hFFF;
    blk <= 1'b1;
    tick(24);
    chk("calls", n_push, p);
    @(posedge clk_in);
    blk <= 1'b0;
    wait_for(0);
    chk("source", src, 4'h3);
    wait_for(1);
    return_from_interrupt;
    wait_for(0);
    chk("source", src, 4'h4);
    wait_for(1);
    swr(4'hB, 1'b0);
    return_from_interrupt;
    $display("order test done");
    @(posedge clk_in);
    len <= 2'h0;
    lsel <= 12'h400;
    swr(4'h3, 1'b1);
    wait_for(0);
    wait_for(1);
    swr(4'h5, 1'b1);
    hw(9'h001);
    wait_for(0);
    chk("source", src, 4'hA);
    chk("in service", insv, 2'h3);
    wait_for(1);
    p = n_push;
    tick(24);
    chk("calls", n_push, p);
    swr(4'h5, 1'b0);
    return_from_interrupt;
    chk("in service", insv, 2'h1);
    swr(4'h3, 1'b0);
    return_from_interrupt;
    wait_for(0);
    chk("source", src, 4'h1);
    wait_for(1);
    return_from_interrupt;
    $display("nesting test done");
    @(posedge clk_in);
    ge <= 1'b0;
    swr(4'h2, 1'b1);
    tick(8);
    swr(4'h2, 1'b0);
    @(posedge clk_in);
    ge <= 1'b1;
    p = n_push;
    tick(16);
    chk("calls", n_push, p);
    $display("forgotten request test done");
    @(posedge clk_in);
    ge <= 1'b0;
    pin_low <= 6'h12;
    tick(8);
    @(posedge clk_in);
    pin_low <= 6'h00;
    tick(8);
    chk("edge flags", flags[5:0], 6'h12);
    swr(4'h1, 1'b0);
    swr(4'h4, 1'b0);
    @(posedge clk_in);
    trig0 <= 1'b0;
    trig1 <= 1'b0;
    pin_low <= 6'h03;
    tick(12);
    chk("level flags", flags[1:0], 2'h3);
    @(posedge clk_in);
    ge <= 1'b1;
    wait_for(0);
    chk("source", src, 4'h0);
    wait_for(1);
    chk("level flags", flags[1:0], 2'h3);
    @(posedge clk_in);
    pin_low <= 6'h00;
    tick(12);
    chk("level flags", flags[1:0], 2'h0);
    $display("pin test done");
    @(posedge clk_in);
    srst_in <= 1'b1;
    tick(3);
    chk("in service", insv, 2'h0);
    @(posedge clk_in);
    srst_in <= 1'b0;
    tick(2);
    chk("phase", phase, 2'h1);
    chk("flags", flags, 15'h0000);
    $display("reset test done");
    summarize;
  end
endmodule
